// >>> design/drive_sig_cfg.svh
// Purpose: Offsets, field positions, reset values and codes for the drive signal outputs
// Assumes: Frequencies in 0.1 Hz steps, percentages in 1 % steps
// Notes:   Included by the package and by the top module
`ifndef DRIVE_SIG_CFG_SVH
`define DRIVE_SIG_CFG_SVH
// Register byte offsets, one 32-bit word each
`define OFS_BAND      8'h00
`define OFS_FWD_THR   8'h04
`define OFS_REV_THR   8'h08
`define OFS_HYST      8'h0C
`define OFS_EXT_DISP  8'h10
`define OFS_OC_SEL    8'h14
`define OFS_RLY_SEL   8'h18
`define OFS_CTRL      8'h1C
`define OFS_STATUS    8'h20
`define OFS_IRQ_STAT  8'h24
`define OFS_IRQ_MASK  8'h28
// Reset values and ranges
`define BAND_RST      16'h000A
`define BAND_MAX      16'h0064
`define FWD_RST       16'h003C
`define THR_MAX       16'h0FA0
`define REV_SAME      16'h270F
`define HYST_RST      16'h0000
`define HYST_MAX      16'h0032
`define EXT_RST       16'h0000
`define OC_SEL_RST    16'h0000
`define RLY_SEL_RST   16'h0063
// Terminal selection codes
`define CODE_AT       16'h0001
`define CODE_FU       16'h0004
`define CODE_CF       16'h005B
`define CODE_ALM      16'h0063
`define CODE_NEG      16'h0064
`define CODE_LIMIT    16'h00C8
// Scale of a percentage
`define PCT_SCALE     24'h000064
// Control register fields
`define CTRL_METH_LSB 0
`define CTRL_FRST_BIT 2
// Status and interrupt bit positions
`define ST_AT         0
`define ST_FU         1
`define ST_ALM        2
`define ST_CF         3
`define ST_OC         4
`define ST_RLY        5
`endif

// >>> design/drive_sig_pkg.sv
// Purpose: Types shared by the drive signal output modules
// Assumes: Constants come from the cfg header
// Notes:   State of each module is one packed struct
`include "drive_sig_cfg.svh"
package drive_sig_pkg;
    // Source of the compared frequency
    typedef enum logic [1:0] {
        METH_VF   = 2'b00,
        METH_FLUX = 2'b01,
        METH_IPM  = 2'b10
    } meth_t;

    // Hysteresis comparator state
    typedef struct packed {
        logic flag;
    } cmp_state_t;

    // Top module state
    typedef struct packed {
        logic        ack;
        logic [31:0] rdat;
        logic [15:0] band;
        logic [15:0] fwd;
        logic [15:0] rev;
        logic [15:0] hyst;
        logic [15:0] ext;
        logic [15:0] oc_sel;
        logic [15:0] rly_sel;
        meth_t       meth;
        logic        fault;
        logic        cfault;
        logic [3:0]  prev;
        logic [3:0]  irq_st;
        logic [3:0]  irq_mask;
        logic        irq;
        logic        oc_term;
        logic        relay;
    } state_t;
endpackage

// >>> design/freq_cmp_if.sv
// Purpose: Carries one hysteresis comparison between the top and a comparator
// Assumes: All signals on the system clock
// Notes:   Flag means lhs <= rhs, released only past rhs + hyst
`timescale 1ns/100ps
interface freq_cmp_if #(parameter int W = 24);
    logic [W-1:0] lhs;      // Left side of the comparison
    logic [W-1:0] rhs;      // Right side
    logic [W-1:0] hyst;     // Release margin
    logic         hold_off; // Forces the flag low
    logic         flag;     // Registered result
    modport ctl (output lhs, rhs, hyst, hold_off, input flag);
    modport cmp (input lhs, rhs, hyst, hold_off, output flag);
endinterface // freq_cmp_if

// >>> design/hyst_compare.sv
// Purpose: Registered less-or-equal comparison with release hysteresis
// Assumes: Inputs stable on the system clock
// Notes:   Sum is one bit wider so it never wraps
`timescale 1ns/100ps
module hyst_compare #(parameter int W = 24) (
    input  wire logic i_sys_clk,
    input  wire logic i_resetn,
    freq_cmp_if.cmp   bus
);
    import drive_sig_pkg::*;

    cmp_state_t s_r;   // Registered state
    cmp_state_t s_nxt; // Next state
    logic [W:0] limit; // Release bound

    // Next flag: set on entry, kept until the bound is passed
    always_comb begin
        s_nxt = s_r;
        limit = {1'b0, bus.rhs} + {1'b0, bus.hyst};
        if (bus.hold_off) begin
            s_nxt.flag = 1'b0;
        end else if (s_r.flag) begin
            s_nxt.flag = ({1'b0, bus.lhs} <= limit);
        end else begin
            s_nxt.flag = (bus.lhs <= bus.rhs);
        end
    end

    // State register
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus.flag = s_r.flag;
endmodule // hyst_compare

// >>> design/drive_signal_outputs.sv
// Purpose: Status flags of a motor drive and their routing to output terminals
// Assumes: Frequency and fault inputs come from logic on i_sys_clk
// Notes:   Terminal outputs are 1 when the terminal conducts
`timescale 1ns/100ps
`include "drive_sig_cfg.svh"
module drive_signal_outputs #(
    parameter int FREQ_W = 16,  // Frequency width, 0.1 Hz steps
    parameter int CMP_W  = 24   // Width of scaled comparisons
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_wb_cyc,
    input  wire logic              i_wb_stb,
    input  wire logic              i_wb_we,
    input  wire logic [7:0]        i_wb_adr,
    input  wire logic [31:0]       i_wb_dat,
    input  wire logic [3:0]        i_wb_sel,
    input  wire logic [FREQ_W-1:0] i_out_freq,
    input  wire logic [FREQ_W-1:0] i_preslip_freq,
    input  wire logic [FREQ_W-1:0] i_rotor_freq,
    input  wire logic [FREQ_W-1:0] i_set_freq,
    input  wire logic              i_reverse,
    input  wire logic              i_dc_brake,
    input  wire logic              i_trip,
    input  wire logic              i_brake_transistor_alarm,
    input  wire logic              i_earth_fault_at_start,
    input  wire logic              i_accel_overcurrent_trip,
    input  wire logic              i_earth_current_seen,
    input  wire logic              i_output_phase_loss,
    input  wire logic              i_param_storage_fault,
    input  wire logic              i_processor_fault,
    input  wire logic              i_inrush_limit_fault,
    output logic      [31:0]       o_wb_dat,
    output logic                   o_wb_ack,
    output logic                   o_irq,
    output logic                   o_at_speed_flag,
    output logic                   o_freq_threshold_flag,
    output logic                   o_fault_flag_out,
    output logic                   o_circuit_fault_flag,
    output logic                   o_open_collector_out,
    output logic                   o_relay_contact_output
);
    import drive_sig_pkg::*;

    // One struct: reset and next copy match
    state_t s_r;   // Registered state
    state_t s_nxt; // Next state

    // Comparator links
    // Each flag is its own register
    freq_cmp_if #(.W(CMP_W)) at_if ();
    freq_cmp_if #(.W(CMP_W)) fu_if ();

    logic [FREQ_W-1:0] cmp_freq;  // Frequency under comparison
    logic [FREQ_W-1:0] diff;      // Distance from the setpoint
    logic [15:0]       thr;       // Active frequency threshold
    logic              cf_event;  // Any circuit fault this cycle
    logic              wb_req;    // New bus request
    logic              cfg_open;  // Frequency settings writable
    logic [3:0]        flags;     // Current flag vector
    logic [3:0]        rise;      // Rising edges of the flags

    // Merge written byte lanes into a 16-bit register
    // Range checks see the merged value
    function automatic logic [15:0] lane16(input logic [15:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0]  sel);
        logic [15:0] r;

        // Lanes 2 and 3 unused: 16-bit words
        r = old;
        if (sel[0]) begin
            r[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            r[15:8] = dat[15:8];
        end
        return r;
    endfunction

    // Conducting state of a terminal for its selection code
    // Negative codes conduct while idle
    function automatic logic term_conduct(input logic [15:0] code,
                                          input logic [3:0]  f);
        logic [15:0] base;
        logic        neg;
        logic        act;
        logic        known;

        base  = code;
        neg   = 1'b0;
        act   = 1'b0;
        known = 1'b1;

        // Codes from 200 up name nothing
        if (code >= `CODE_LIMIT) begin
            known = 1'b0;
        end else if (code >= `CODE_NEG) begin
            base = code - `CODE_NEG;
            neg  = 1'b1;
        end

        // Base code picks the flag
        case (base)
            `CODE_AT:  act = f[`ST_AT];
            `CODE_FU:  act = f[`ST_FU];
            `CODE_CF:  act = f[`ST_CF];
            `CODE_ALM: act = f[`ST_ALM];
            default:   known = 1'b0;
        endcase
        // Unassigned code never conducts, whatever its polarity
        return known & (act ^ neg);
    endfunction

    // Compared frequency by control method
    // Method is registered: one edge late
    always_comb begin
        case (s_r.meth)
            METH_VF:   cmp_freq = i_out_freq;
            METH_FLUX: cmp_freq = i_preslip_freq;
            METH_IPM:  cmp_freq = i_rotor_freq;
            default:   cmp_freq = i_out_freq;
        endcase
    end

    // Distance from the setpoint, always positive
    // Larger side first: no wrap
    assign diff = (cmp_freq >= i_set_freq) ? cmp_freq - i_set_freq
                                           : i_set_freq - cmp_freq;

    // Reverse threshold only when set and turning in reverse
    // Sentinel means one threshold both ways
    assign thr = (i_reverse && s_r.rev != `REV_SAME) ? s_r.rev : s_r.fwd;

    // At-speed: diff*100 <= set*band, division avoided on purpose
    // Casts keep products at CMP_W bits
    assign at_if.lhs      = CMP_W'(CMP_W'(diff) * `PCT_SCALE);
    assign at_if.rhs      = CMP_W'(i_set_freq) * CMP_W'(s_r.band);
    assign at_if.hyst     = CMP_W'(CMP_W'(s_r.hyst) * `PCT_SCALE);
    assign at_if.hold_off = i_dc_brake;

    // Threshold: thr <= freq, released below thr - hyst
    // Sides swapped: one comparator type
    assign fu_if.lhs      = CMP_W'(thr);
    assign fu_if.rhs      = CMP_W'(cmp_freq);
    assign fu_if.hyst     = CMP_W'(s_r.hyst);
    assign fu_if.hold_off = i_dc_brake;

    // At-speed comparator
    // Its flag is a register, glitch free
    hyst_compare #(.W(CMP_W)) u_at_cmp (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .bus       (at_if.cmp)
    );

    // Frequency threshold comparator
    // Braking holds it low as well
    hyst_compare #(.W(CMP_W)) u_fu_cmp (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .bus       (fu_if.cmp)
    );

    // Circuit faults; an earth fault shown as accel overcurrent still counts
    // Accel overcurrent alone: trip only
    assign cf_event = i_brake_transistor_alarm | i_earth_fault_at_start
                    | (i_accel_overcurrent_trip & i_earth_current_seen)
                    | i_output_phase_loss | i_param_storage_fault
                    | i_processor_fault | i_inrush_limit_fault;

    // Bus request decode; ack gap makes every access two cycles apart
    assign wb_req   = i_wb_cyc & i_wb_stb & ~s_r.ack;
    // Selectors stay writable when locked
    assign cfg_open = (s_r.ext == 16'h0000);

    // Flag vector and its edges feed status and interrupts
    // Bit order matches the status word
    assign flags = {s_r.cfault, s_r.fault, fu_if.flag, at_if.flag};
    // Edge memory resets to idle: no false edge
    assign rise  = flags & ~s_r.prev;

    // Next state: bus slave, fault latches, interrupts, terminals
    always_comb begin
        s_nxt      = s_r;
        s_nxt.ack  = wb_req;
        s_nxt.prev = flags;

        // Fault reset from software, a new trip in the same cycle wins
        // Set after clear gives the set priority
        if (wb_req && i_wb_we && i_wb_adr == `OFS_CTRL && i_wb_sel[0]
            && i_wb_dat[`CTRL_FRST_BIT]) begin
            s_nxt.fault  = 1'b0;
            s_nxt.cfault = 1'b0;
        end

        // Any trip latches the fault flag
        if (i_trip || cf_event) begin
            s_nxt.fault = 1'b1;
        end

        // Circuit faults latch their own flag
        if (cf_event) begin
            s_nxt.cfault = 1'b1;
        end

        // Register writes; out-of-range settings are dropped
        // Dropped, not clamped: reads stay true
        // Writes land at the ack edge
        if (wb_req && i_wb_we) begin
            case (i_wb_adr)
                `OFS_BAND: begin
                    if (cfg_open && lane16(s_r.band, i_wb_dat, i_wb_sel) <= `BAND_MAX) begin
                        s_nxt.band = lane16(s_r.band, i_wb_dat, i_wb_sel);
                    end
                end
                `OFS_FWD_THR: begin
                    if (cfg_open && lane16(s_r.fwd, i_wb_dat, i_wb_sel) <= `THR_MAX) begin
                        s_nxt.fwd = lane16(s_r.fwd, i_wb_dat, i_wb_sel);
                    end
                end
                `OFS_REV_THR: begin
                    // Sentinel value is accepted beside the range
                    // though it lies above it
                    if (cfg_open && (lane16(s_r.rev, i_wb_dat, i_wb_sel) <= `THR_MAX
                        || lane16(s_r.rev, i_wb_dat, i_wb_sel) == `REV_SAME)) begin
                        s_nxt.rev = lane16(s_r.rev, i_wb_dat, i_wb_sel);
                    end
                end
                `OFS_HYST: begin
                    if (cfg_open && lane16(s_r.hyst, i_wb_dat, i_wb_sel) <= `HYST_MAX) begin
                        s_nxt.hyst = lane16(s_r.hyst, i_wb_dat, i_wb_sel);
                    end
                end
                `OFS_EXT_DISP: begin
                    s_nxt.ext = lane16(s_r.ext, i_wb_dat, i_wb_sel);
                end
                `OFS_OC_SEL: begin
                    s_nxt.oc_sel = lane16(s_r.oc_sel, i_wb_dat, i_wb_sel);
                end
                `OFS_RLY_SEL: begin
                    s_nxt.rly_sel = lane16(s_r.rly_sel, i_wb_dat, i_wb_sel);
                end
                `OFS_CTRL: begin
                    // Unused method code falls back to output frequency
                    if (i_wb_sel[0]) begin
                        s_nxt.meth = meth_t'(i_wb_dat[`CTRL_METH_LSB +: 2]);
                    end
                end
                `OFS_IRQ_MASK: begin
                    if (i_wb_sel[0]) begin
                        s_nxt.irq_mask = i_wb_dat[3:0];
                    end
                end
                default: begin
                    // Read-only and unmapped words ignore writes
                end
            endcase
        end

        // Write one to clear, a new edge in the same cycle wins
        // Interrupt follows next status and mask
        if (wb_req && i_wb_we && i_wb_adr == `OFS_IRQ_STAT && i_wb_sel[0]) begin
            s_nxt.irq_st = s_r.irq_st & ~i_wb_dat[3:0];
        end
        s_nxt.irq_st = s_nxt.irq_st | rise;
        s_nxt.irq    = |(s_nxt.irq_st & s_nxt.irq_mask);

        // Read data, zero for unmapped words and during writes
        // Fault reset bit is a strobe
        s_nxt.rdat = 32'h0000_0000;
        if (wb_req && !i_wb_we) begin
            case (i_wb_adr)
                `OFS_BAND:     s_nxt.rdat = {16'h0000, s_r.band};
                `OFS_FWD_THR:  s_nxt.rdat = {16'h0000, s_r.fwd};
                `OFS_REV_THR:  s_nxt.rdat = {16'h0000, s_r.rev};
                `OFS_HYST:     s_nxt.rdat = {16'h0000, s_r.hyst};
                `OFS_EXT_DISP: s_nxt.rdat = {16'h0000, s_r.ext};
                `OFS_OC_SEL:   s_nxt.rdat = {16'h0000, s_r.oc_sel};
                `OFS_RLY_SEL:  s_nxt.rdat = {16'h0000, s_r.rly_sel};
                `OFS_CTRL:     s_nxt.rdat = {30'h0000_0000, s_r.meth};
                `OFS_STATUS:   s_nxt.rdat = {26'h000_0000, s_r.relay, s_r.oc_term, flags};
                `OFS_IRQ_STAT: s_nxt.rdat = {28'h000_0000, s_r.irq_st};
                `OFS_IRQ_MASK: s_nxt.rdat = {28'h000_0000, s_r.irq_mask};
                default:       s_nxt.rdat = 32'h0000_0000;
            endcase
        end

        // Terminal drive from the selection codes
        // One cycle behind the flags, the price
        // paid for registered outputs
        s_nxt.oc_term = term_conduct(s_r.oc_sel, flags);
        s_nxt.relay   = term_conduct(s_r.rly_sel, flags);
    end

    // State register; relay selection starts on the fault flag
    // Constants only in the reset branch
    // so reset never waits on logic
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_r          <= '0;
            s_r.band     <= `BAND_RST;
            s_r.fwd      <= `FWD_RST;
            s_r.rev      <= `REV_SAME;
            s_r.hyst     <= `HYST_RST;
            s_r.ext      <= `EXT_RST;
            s_r.oc_sel   <= `OC_SEL_RST;
            s_r.rly_sel  <= `RLY_SEL_RST;
            s_r.meth     <= METH_VF;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from registers
    // No logic between flop and pin
    // At-speed and threshold flags come from the comparators
    assign o_wb_dat               = s_r.rdat;
    assign o_wb_ack               = s_r.ack;
    assign o_irq                  = s_r.irq;
    assign o_at_speed_flag        = at_if.flag;
    assign o_freq_threshold_flag  = fu_if.flag;
    assign o_fault_flag_out       = s_r.fault;
    assign o_circuit_fault_flag   = s_r.cfault;
    assign o_open_collector_out   = s_r.oc_term;
    assign o_relay_contact_output = s_r.relay;
endmodule // drive_signal_outputs

// >>> verification/drive_sig_sva.sv
// Purpose: Port-level checker for the drive signal outputs
// Assumes: Single clock, async active-low reset
// Notes:   Sees only top ports; bound at the foot of this file
`timescale 1ns/100ps
`include "drive_sig_cfg.svh"
module drive_sig_chk (
    input wire logic        i_sys_clk,
    input wire logic        i_resetn,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [7:0]  i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0]  i_wb_sel,
    input wire logic        i_dc_brake,
    input wire logic        i_trip,
    input wire logic        i_brake_transistor_alarm,
    input wire logic        i_earth_fault_at_start,
    input wire logic        i_accel_overcurrent_trip,
    input wire logic        i_earth_current_seen,
    input wire logic        i_output_phase_loss,
    input wire logic        i_param_storage_fault,
    input wire logic        i_processor_fault,
    input wire logic        i_inrush_limit_fault,
    input wire logic        o_wb_ack,
    input wire logic        o_at_speed_flag,
    input wire logic        o_freq_threshold_flag,
    input wire logic        o_fault_flag_out,
    input wire logic        o_circuit_fault_flag,
    input wire logic        o_open_collector_out,
    input wire logic        o_relay_contact_output
);
    logic       take; // Request taken this edge
    logic       frst; // Fault reset write taken
    logic       cfin; // Any direct circuit fault
    logic [3:0] fl;   // All four flags
    assign take = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign frst = take & i_wb_we & (i_wb_adr == `OFS_CTRL) & i_wb_sel[0] & i_wb_dat[2];
    assign cfin = i_brake_transistor_alarm | i_earth_fault_at_start | i_output_phase_loss
                | i_param_storage_fault | i_processor_fault | i_inrush_limit_fault;
    assign fl   = {o_at_speed_flag, o_freq_threshold_flag, o_fault_flag_out,
                   o_circuit_fault_flag};
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    a_ack_after_take: assert property (take |=> o_wb_ack)
        else $error("No ack one cycle after request");
    a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("Ack longer than one cycle");
    a_trip_sets_fault: assert property (i_trip |=> o_fault_flag_out)
        else $error("Trip did not raise fault flag");
    a_fault_holds: assert property (o_fault_flag_out && !frst |=> o_fault_flag_out)
        else $error("Fault flag fell without reset");
    a_circuit_fault_set: assert property (cfin |=> o_circuit_fault_flag)
        else $error("Circuit fault not flagged");
    a_earth_as_oc: assert property (i_accel_overcurrent_trip
        && i_earth_current_seen |=> o_circuit_fault_flag)
        else $error("Earth fault shown as overcurrent not flagged");
    a_brake_clears_flags: assert property (i_dc_brake
        |=> !o_at_speed_flag && !o_freq_threshold_flag)
        else $error("Frequency flag during braking");
    a_cf_implies_fault: assert property (o_circuit_fault_flag |-> o_fault_flag_out)
        else $error("Circuit fault without fault flag");
    a_term_has_cause: assert property (($changed(o_open_collector_out)
        || $changed(o_relay_contact_output)) |-> ($past(fl) != $past(fl, 2))
        || $past(o_wb_ack))
        else $error("Terminal changed without cause");
    c_trip: cover property (i_trip ##1 o_fault_flag_out);
    c_brake: cover property (o_at_speed_flag ##0 i_dc_brake);
    c_earth_oc: cover property (i_accel_overcurrent_trip && i_earth_current_seen);
endmodule // drive_sig_chk
bind drive_signal_outputs drive_sig_chk i_drive_sig_chk (.*);

// >>> verification/term_reader.sv
// Purpose: Equipment reading the two output terminals
// Assumes: Open collector line has a pull-up
// Notes:   Terminal input 1 means the terminal conducts
`timescale 1ns/100ps
module term_reader (
    input  wire logic i_oc_conduct,  // Transistor sinks the line
    input  wire logic i_rly_conduct, // Contact closed
    output logic      o_oc_line,     // Line level seen
    output logic      o_rly_closed   // Contact state seen
);
    // Pull-up wins unless the transistor sinks the line
    assign o_oc_line    = i_oc_conduct ? 1'b0 : 1'b1;
    assign o_rly_closed = i_rly_conduct;
endmodule // term_reader

// >>> verification/testbench.sv
// Purpose: Bus and terminal tests of the drive signal outputs
// Assumes: Frequencies in 0.1 Hz steps
// Notes:   Flag vector order is at, fu, fault, cfault, oc line, relay
`timescale 1ns/100ps
`include "drive_sig_cfg.svh"
module testbench;
    logic        clk, rstn, cyc, stb, we; // Clock, reset, bus strobes
    logic [7:0]  adr, flt;                // Address, circuit fault causes
    logic [31:0] wd, rd, dat;             // Write, taken and bus read data
    logic [15:0] fo, fp, fr, fs;          // Out, pre-slip, rotor, set
    logic        rev, dcb, trip, ack, irq;
    logic        at, fu, al, cf, oc, rl, ocl, rlc;
    int          fails, num_checks;
    drive_signal_outputs i_drive_signal_outputs (.i_sys_clk(clk), .i_resetn(rstn),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wd),
        .i_wb_sel(4'hF), .i_out_freq(fo), .i_preslip_freq(fp), .i_rotor_freq(fr),
        .i_set_freq(fs), .i_reverse(rev), .i_dc_brake(dcb), .i_trip(trip),
        .i_brake_transistor_alarm(flt[0]), .i_earth_fault_at_start(flt[1]),
        .i_output_phase_loss(flt[2]), .i_param_storage_fault(flt[3]),
        .i_processor_fault(flt[4]), .i_inrush_limit_fault(flt[5]),
        .i_accel_overcurrent_trip(flt[6]), .i_earth_current_seen(flt[7]),
        .o_wb_dat(dat), .o_wb_ack(ack), .o_irq(irq), .o_at_speed_flag(at),
        .o_freq_threshold_flag(fu), .o_fault_flag_out(al), .o_circuit_fault_flag(cf),
        .o_open_collector_out(oc), .o_relay_contact_output(rl));
    term_reader i_term_reader (.i_oc_conduct(oc), .i_rly_conduct(rl), .o_oc_line(ocl),
        .o_rly_closed(rlc));
    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Verdict and end of run
    task automatic stop_test;
        $display("Compares %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t got %0h want %0h", $time, g, e);
        end
    endtask
    // One classic cycle; held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = dat;
        {cyc, stb} <= 2'b00;
        if (n >= 20) begin
            $display("[FAIL] %0t bus timeout", $time);
            fails++;
            stop_test();
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // Flags land one edge late, terminals one more
    task automatic see(input logic [5:0] e);
        repeat (3) @(posedge clk);
        chk({26'h0, at, fu, al, cf, ocl, rlc}, {26'h0, e});
    endtask
    task automatic fq(input logic [15:0] f);
        @(posedge clk);
        fo <= f;
    endtask
    task automatic done(input string s);
        $display("Test %s finished", s);
    endtask
    // Main sequence
    initial begin
        {cyc, stb, we, adr, wd, flt, rev, dcb, trip} = '0;
        {fo, fp, fr} = '0;
        fs = 16'h01F4;
        {fails, num_checks} = '0;
        rstn = 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rdc(`OFS_BAND, `BAND_RST);
        rdc(`OFS_FWD_THR, `FWD_RST);
        rdc(`OFS_REV_THR, `REV_SAME);
        rdc(`OFS_HYST, `HYST_RST);
        rdc(`OFS_RLY_SEL, `RLY_SEL_RST);
        rdc(8'h3C, 32'h0);
        see(6'b000010);
        done("reset");
        bus(1'b1, `OFS_IRQ_MASK, 32'h4);
        @(posedge clk) trip <= 1'b1;
        @(posedge clk) trip <= 1'b0;
        see(6'b001011);
        chk(irq, 1'b1);
        bus(1'b1, `OFS_IRQ_STAT, 32'h4);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        bus(1'b1, `OFS_RLY_SEL, 32'hC7);
        see(6'b001010);
        bus(1'b1, `OFS_CTRL, 32'h4);
        see(6'b000011);
        bus(1'b1, `OFS_RLY_SEL, 32'h63);
        bus(1'b1, `OFS_OC_SEL, 32'h5B);
        for (int i = 0; i < 7; i++) begin
            @(posedge clk) flt <= (i < 6) ? 8'(1 << i) : 8'hC0;
            @(posedge clk) flt <= 8'h0;
            see(6'b001101);
            bus(1'b1, `OFS_CTRL, 32'h4);
            see(6'b000010);
        end
        bus(1'b1, `OFS_OC_SEL, 32'hBF);
        see(6'b000000);
        done("faults");
        bus(1'b1, `OFS_OC_SEL, 32'h4);
        fq(16'h003B);
        see(6'b000010);
        fq(16'h003C);
        see(6'b010000);
        bus(1'b1, `OFS_HYST, 32'hA);
        fq(16'h0032);
        see(6'b010000);
        fq(16'h0031);
        see(6'b000010);
        bus(1'b1, `OFS_REV_THR, 32'h64);
        @(posedge clk) rev <= 1'b1;
        fq(16'h0050);
        see(6'b000010);
        fq(16'h0064);
        see(6'b010000);
        bus(1'b1, `OFS_REV_THR, 32'h270F);
        fq(16'h0031);
        fq(16'h003C);
        see(6'b010000);
        bus(1'b1, `OFS_OC_SEL, 32'h68);
        see(6'b010010);
        done("threshold");
        @(posedge clk) rev <= 1'b0;
        bus(1'b1, `OFS_HYST, 32'h0);
        bus(1'b1, `OFS_OC_SEL, 32'h1);
        fq(16'h01C2);
        see(6'b110000);
        fq(16'h01C1);
        see(6'b010010);
        fq(16'h0226);
        see(6'b110000);
        @(posedge clk) dcb <= 1'b1;
        see(6'b000010);
        bus(1'b1, `OFS_OC_SEL, 32'h65);
        see(6'b000000);
        @(posedge clk) dcb <= 1'b0;
        bus(1'b1, `OFS_OC_SEL, 32'h1);
        fq(16'h0000);
        @(posedge clk) {fp, fr} <= {16'h01F4, 16'h0000};
        bus(1'b1, `OFS_CTRL, 32'h1);
        see(6'b110000);
        bus(1'b1, `OFS_CTRL, 32'h2);
        see(6'b000010);
        @(posedge clk) fr <= 16'h01F4;
        see(6'b110000);
        done("speed");
        bus(1'b1, `OFS_EXT_DISP, 32'h1);
        bus(1'b1, `OFS_BAND, 32'h14);
        rdc(`OFS_BAND, `BAND_RST);
        bus(1'b1, `OFS_EXT_DISP, 32'h0);
        bus(1'b1, `OFS_BAND, 32'h14);
        rdc(`OFS_BAND, 32'h14);
        bus(1'b1, `OFS_OC_SEL, 32'h6B);
        see(6'b110010);
        bus(1'b1, `OFS_OC_SEL, 32'hFA);
        see(6'b110010);
        done("settings");
        stop_test();
    end
endmodule // testbench
